/* verilog/mpm_pkg.sv */
// mpm_pkg: constants for the menu parameter mapper
// assumes: single 200 MHz clock domain, used by mpm_menu_mapper and its testbench
package mpm_pkg;
    // menu numbers
    localparam logic [6:0] MPM_MENU_A      = 7'h12; // paired 16-bit menu (18)
    localparam logic [6:0] MPM_MENU_B      = 7'h13; // paired 16-bit menu (19)
    localparam logic [6:0] MPM_MENU_W      = 7'h14; // wide menu (20)
    localparam logic [6:0] MPM_MENU_NUM    = 7'h46; // numbered access menu (70)
    // slot ranges
    localparam logic [6:0] MPM_RO_FIRST    = 7'h02; // first read-only slot, menus 18/19
    localparam logic [6:0] MPM_RO_LAST     = 7'h0a; // last read-only slot
    localparam logic [6:0] MPM_MAP_LAST    = 7'h1e; // last mapped slot (30)
    localparam logic [6:0] MPM_W_FIRST     = 7'h01; // first menu 20 slot
    localparam logic [6:0] MPM_W16_LAST    = 7'h14; // last 16-bit menu 20 slot (20)
    localparam logic [6:0] MPM_W_LAST      = 7'h28; // last menu 20 slot (40)
    // word order settings
    localparam logic       MPM_ORDER_MSW_LSW = 1'b0; // default: low half in lower slot
    localparam logic       MPM_ORDER_RESET   = MPM_ORDER_MSW_LSW;
    // menu access source codes
    localparam logic [1:0] MPM_SRC_CYCLIC  = 2'h0; // cyclic fieldbus menu access
    localparam logic [1:0] MPM_SRC_NONCYC  = 2'h1; // non-cyclic fieldbus / explicit / modbus
    localparam logic [1:0] MPM_SRC_FRONT   = 2'h2; // front-panel modbus rtu
    localparam logic [31:0] MPM_DATA_RESET = 32'h0000_0000;
    // service scheduler states
    typedef enum logic [1:0] {MPM_IDLE, MPM_PUSH, MPM_PULL, MPM_DONE} mpm_state_t;
endpackage : mpm_pkg

/* verilog/mpm_menu_mapper.sv */
// mpm_menu_mapper: one mapping slot between an internal parameter and a drive menu
// assumes: internal parameter and menu request share ref_clk; inputs are synchronous
// Functional notes
// - 32-bit in menu 18/19 uses two slots
// - word order selects which slot holds halves
// - menu 18 slots 2-10 read-only, 11-30 mapped
// - menu 19 slots 2-10 read-only, 11-30 mapped
// - menu 20: slots 1-20 16-bit, 21-40 32-bit
// - menu 20 parameter occupies one slot
// - values cross as scaled plain integers
// - writable parameter: changes flow both ways
// - read-only parameter: menu shows, writes refused with an error
// - copying runs asynchronously at program priority
// - menu 70 number reaches internal parameter
// - numbered parameters blocked from front-panel modbus
`timescale 1ns/1ps
module mpm_menu_mapper
    import mpm_pkg::*;
#(
    parameter int DW = 32 // internal parameter width
) (
    input  wire logic          ref_clk,
    input  wire logic          arst_n,
    // mapping configuration
    input  wire logic [6:0]    cfg_menu,       // menu the parameter is mapped to
    input  wire logic [6:0]    cfg_slot,       // first slot of the mapping
    input  wire logic          cfg_wide,       // parameter is 32-bit
    input  wire logic          cfg_swap,       // word order: 1 puts high half in lower slot
    input  wire logic          cfg_par_ro,     // internal parameter is read-only
    input  wire logic [15:0]   cfg_drive_num,  // assigned drive parameter number (menu 70)
    input  wire logic          cfg_num_en,     // numbered access enabled
    // internal side: scaled integer value
    input  wire logic [DW-1:0] par_value,      // current scaled internal value
    input  wire logic          par_changed,    // internal value updated (pulse)
    input  wire logic          svc_slot,       // program-priority service slot (pulse)
    // menu side request
    input  wire logic          mreq_valid,     // menu access request
    input  wire logic          mreq_write,     // 1 write, 0 read
    input  wire logic [1:0]    mreq_src,       // request source
    input  wire logic [6:0]    mreq_menu,      // menu number, or 70 for numbered access
    input  wire logic [6:0]    mreq_slot,      // slot within menu
    input  wire logic [15:0]   mreq_num,       // drive parameter number for menu 70
    input  wire logic [31:0]   mreq_wdata,     // write data
    // menu side answer
    output logic               mrsp_valid,     // answer strobe
    output logic               mrsp_err,       // request refused
    output logic [31:0]        mrsp_rdata,     // read data
    // internal write-back
    output logic               par_wr,         // write internal parameter (pulse)
    output logic [DW-1:0]      par_wdata       // scaled value to store
);

    ////////////////////////////////////////////////////////////////////////
    // address classification helpers

    // which part of the mapping a slot hits: 01 first slot, 10 second half, 00 none
    function automatic logic [1:0] hit_part(input logic [6:0] menu,
                                            input logic [6:0] slot,
                                            input logic [6:0] c_menu,
                                            input logic [6:0] c_slot,
                                            input logic       wide);
        logic [6:0] nxt;
        nxt = 7'(c_slot + 7'h01);
        hit_part = 2'b00;
        if (menu == c_menu && slot == c_slot)
            hit_part = 2'b01;                          // first slot
        else if (menu == c_menu && slot == nxt && wide &&
                 (c_menu == MPM_MENU_A || c_menu == MPM_MENU_B))
            hit_part = 2'b10;                          // second half
    endfunction : hit_part

    // config legality of a menu/slot placement
    function automatic logic place_ok(input logic [6:0] menu,
                                      input logic [6:0] slot,
                                      input logic       wide);
        place_ok = 1'b0;
        if (menu == MPM_MENU_A || menu == MPM_MENU_B)
            // paired menus: only slots above the read-only block are mappable
            // eight-bit sum so that a top slot cannot wrap into range
            place_ok = (slot > MPM_RO_LAST) &&
                       (({1'b0, slot} + {7'h00, wide}) <= {1'b0, MPM_MAP_LAST});
        else if (menu == MPM_MENU_W)
            // wide menu: width picks the slot block, one slot each
            place_ok = wide ? (slot > MPM_W16_LAST && slot <= MPM_W_LAST)
                            : (slot >= MPM_W_FIRST && slot <= MPM_W16_LAST);
    endfunction : place_ok

    ////////////////////////////////////////////////////////////////////////
    // state

    mpm_state_t      st_q, st_d;         // service scheduler
    logic [31:0]     menu_q, menu_d;     // menu-side image, both halves
    logic [31:0]     pend_q, pend_d;     // menu write waiting for service
    logic            pend_v_q, pend_v_d; // menu write pending
    logic            dirty_q, dirty_d;   // internal change waiting for service
    logic            rsp_v_q, rsp_v_d;
    logic            rsp_e_q, rsp_e_d;
    logic [31:0]     rsp_d_q, rsp_d_d;
    logic            wr_q, wr_d;
    logic [DW-1:0]   wd_q, wd_d;

    // word-ordered halves of the menu image
    logic [15:0]     lo_slot_val;        // value shown in lower-numbered slot
    logic [15:0]     hi_slot_val;        // value shown in higher-numbered slot
    logic [1:0]      part;
    logic            num_hit;
    logic            ro_area;
    logic            ok_cfg;
    logic            take_wr;            // menu write accepted this cycle

    ////////////////////////////////////////////////////////////////////////
    // combinational next state

    always_comb begin
        st_d     = st_q;
        menu_d   = menu_q;
        pend_d   = pend_q;
        pend_v_d = pend_v_q;
        dirty_d  = dirty_q | par_changed;
        rsp_v_d  = 1'b0;
        rsp_e_d  = 1'b0;
        rsp_d_d  = rsp_d_q;
        wr_d     = 1'b0;
        wd_d     = wd_q;
        take_wr  = 1'b0;
        ok_cfg   = place_ok(cfg_menu, cfg_slot, cfg_wide);
        // swap puts high half in lower slot, default low half there
        lo_slot_val = cfg_swap ? menu_q[31:16] : menu_q[15:0];
        hi_slot_val = cfg_swap ? menu_q[15:0]  : menu_q[31:16];
        part     = hit_part(mreq_menu, mreq_slot, cfg_menu, cfg_slot, cfg_wide);
        num_hit  = (mreq_menu == MPM_MENU_NUM) && cfg_num_en &&
                   (mreq_num == cfg_drive_num);
        ro_area  = (mreq_menu == MPM_MENU_A || mreq_menu == MPM_MENU_B) &&
                   mreq_slot >= MPM_RO_FIRST && mreq_slot <= MPM_RO_LAST;

        // menu-side request, answered next cycle
        if (mreq_valid) begin
            rsp_v_d = 1'b1;
            if (num_hit && mreq_src == MPM_SRC_FRONT) begin
                rsp_e_d = 1'b1;
            end else if (num_hit || (part != 2'b00 && ok_cfg)) begin
                // read: whole value on numbered/menu 20, one half on 18/19
                if (num_hit || mreq_menu == MPM_MENU_W)
                    rsp_d_d = menu_q;
                else if (part == 2'b01)
                    rsp_d_d = cfg_wide ? {16'h0000, lo_slot_val}
                                       : {16'h0000, menu_q[15:0]};
                else
                    rsp_d_d = {16'h0000, hi_slot_val};
                if (mreq_write) begin
                    if (cfg_par_ro) begin
                        rsp_e_d = 1'b1;
                    end else begin
                        // merge half into a shadow; commit both halves at once
                        if (num_hit || mreq_menu == MPM_MENU_W || !cfg_wide)
                            pend_d = mreq_wdata;
                        else if ((part == 2'b01) != cfg_swap)
                            pend_d = {pend_q[31:16], mreq_wdata[15:0]};
                        else
                            pend_d = {mreq_wdata[15:0], pend_q[15:0]};
                        pend_v_d = 1'b1;
                        take_wr  = 1'b1;
                    end
                end
            end else if (ro_area && mreq_write) begin
                rsp_e_d = 1'b1;
            end else if (!ro_area) begin
                rsp_e_d = 1'b1;                                 // unmapped slot
            end else begin
                rsp_d_d = 32'h0000_0000;                        // unused read-only slot
            end
        end

        // copy service, run only in program-priority slots
        case (st_q)
            MPM_IDLE: begin
                if (svc_slot && pend_v_q)
                    st_d = MPM_PULL;
                else if (svc_slot && dirty_q)
                    st_d = MPM_PUSH;
            end
            MPM_PUSH: begin
                // internal change refreshes both halves in one step
                menu_d  = 32'(par_value);
                // a menu write taken in this same cycle keeps its shadow
                if (!take_wr)
                    pend_d = 32'(par_value);
                dirty_d = par_changed;
                st_d    = MPM_DONE;
            end
            MPM_PULL: begin
                // menu write reaches the internal parameter unscaled
                // a read-only parameter is never written back
                wr_d     = !cfg_par_ro;
                wd_d     = DW'(pend_q);
                if (!cfg_par_ro)
                    menu_d = pend_q;
                // set wins: a write or a change in this cycle stays pending
                pend_v_d = take_wr;
                dirty_d  = par_changed;
                st_d     = MPM_DONE;
            end
            MPM_DONE: st_d = MPM_IDLE;
            default:  st_d = MPM_IDLE;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////
    // registers

    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            st_q     <= MPM_IDLE;
            menu_q   <= MPM_DATA_RESET;
            pend_q   <= MPM_DATA_RESET;
            pend_v_q <= 1'b0;
            dirty_q  <= 1'b1;               // first service copies the value out
            rsp_v_q  <= 1'b0;
            rsp_e_q  <= 1'b0;
            rsp_d_q  <= MPM_DATA_RESET;
            wr_q     <= 1'b0;
            wd_q     <= '0;
        end else begin
            st_q     <= st_d;
            menu_q   <= menu_d;
            pend_q   <= pend_d;
            pend_v_q <= pend_v_d;
            dirty_q  <= dirty_d;
            rsp_v_q  <= rsp_v_d;
            rsp_e_q  <= rsp_e_d;
            rsp_d_q  <= rsp_d_d;
            wr_q     <= wr_d;
            wd_q     <= wd_d;
        end
    end

    // outputs straight from flip-flops
    assign mrsp_valid = rsp_v_q;
    assign mrsp_err   = rsp_e_q;
    assign mrsp_rdata = rsp_d_q;
    assign par_wr     = wr_q;
    assign par_wdata  = wd_q;

endmodule : mpm_menu_mapper

/* testbench/mpm_menu_mapper_props.sv */
// mpm_menu_mapper_props: port properties of the menu mapper
// assumes: bound into mpm_menu_mapper, single clock ref_clk, reset arst_n
`timescale 1ns/1ps
module mpm_menu_mapper_props
    import mpm_pkg::*;
(
    input wire logic        ref_clk,
    input wire logic        arst_n,
    input wire logic        cfg_par_ro,
    input wire logic [15:0] cfg_drive_num,
    input wire logic        cfg_num_en,
    input wire logic        svc_slot,
    input wire logic        mreq_valid,
    input wire logic        mreq_write,
    input wire logic [1:0]  mreq_src,
    input wire logic [6:0]  mreq_menu,
    input wire logic [6:0]  mreq_slot,
    input wire logic [15:0] mreq_num,
    input wire logic        mrsp_valid,
    input wire logic        mrsp_err,
    input wire logic [31:0] mrsp_rdata,
    input wire logic        par_wr
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!arst_n);
    ////////////////////////////////////////////////////////////////////////
    // write request on the menu bus
    sequence s_wr;
        mreq_valid && mreq_write;
    endsequence
    // slot in the read-only range of the paired menus
    sequence s_ro_slot;
        (mreq_menu == MPM_MENU_A || mreq_menu == MPM_MENU_B) &&
        mreq_slot >= MPM_RO_FIRST && mreq_slot <= MPM_RO_LAST;
    endsequence
    // request aimed at the assigned drive parameter number
    sequence s_num_hit;
        mreq_valid && cfg_num_en && mreq_menu == MPM_MENU_NUM && mreq_num == cfg_drive_num;
    endsequence
    ////////////////////////////////////////////////////////////////////////
    resp_timing_a: assert property (mrsp_valid == $past(mreq_valid))
        else $error("answer strobe not one cycle after request");
    ro_write_refused_a: assert property (s_wr ##0 cfg_par_ro |=> mrsp_err)
        else $error("write to read-only parameter accepted");
    ro_param_hold_a: assert property ($past(cfg_par_ro, 2) && cfg_par_ro |-> !par_wr)
        else $error("read-only parameter written back");
    ro_slot_refused_a: assert property (s_wr ##0 s_ro_slot |=> mrsp_err)
        else $error("write to read-only slot accepted");
    ro_slot_read_a: assert property (
        mreq_valid && !mreq_write ##0 s_ro_slot |=> !mrsp_err && mrsp_rdata == 32'h0000_0000)
        else $error("unused read-only slot read wrong");
    front_refused_a: assert property (s_num_hit ##0 mreq_src == MPM_SRC_FRONT |=> mrsp_err)
        else $error("front panel reached numbered parameter");
    numbered_ok_a: assert property (
        s_num_hit ##0 (mreq_src == MPM_SRC_NONCYC && !(mreq_write && cfg_par_ro))
        |=> mrsp_valid && !mrsp_err)
        else $error("numbered access refused");
    svc_order_a: assert property (par_wr |-> $past(svc_slot, 2))
        else $error("write-back not two cycles after service slot");
endmodule : mpm_menu_mapper_props

bind mpm_menu_mapper mpm_menu_mapper_props mpm_menu_mapper_props_inst (.ref_clk, .arst_n,
    .cfg_par_ro, .cfg_drive_num, .cfg_num_en, .svc_slot, .mreq_valid, .mreq_write, .mreq_src,
    .mreq_menu, .mreq_slot, .mreq_num, .mrsp_valid, .mrsp_err, .mrsp_rdata, .par_wr);

/* testbench/mpm_host_model.sv */
// mpm_host_model: menu master standing on the drive side of the mapper
// assumes: requests launch on the falling edge of ref_clk, one at a time
`timescale 1ns/1ps
module mpm_host_model (
    output logic             mreq_valid,
    output logic             mreq_write,
    output logic [1:0]       mreq_src,
    output logic [6:0]       mreq_menu,
    output logic [6:0]       mreq_slot,
    output logic [15:0]      mreq_num,
    output logic [31:0]      mreq_wdata,
    input  wire logic        ref_clk,
    input  wire logic        mrsp_valid,
    input  wire logic        mrsp_err,
    input  wire logic [31:0] mrsp_rdata
);
    logic [64:0] req_q = '0; // all qualifiers of one request
    assign {mreq_write, mreq_src, mreq_menu, mreq_slot, mreq_num, mreq_wdata} = req_q;
    initial mreq_valid = 1'b0;
    ////////////////////////////////////////////////////////////////////////
    // one access: held over the taking edge, answer read while it stands
    task automatic access(input logic w, input logic [1:0] src, input logic [6:0] menu,
                          input logic [6:0] slot, input logic [15:0] num,
                          input logic [31:0] wd, output logic vl, output logic e,
                          output logic [31:0] rd);
        @(negedge ref_clk);
        req_q = {w, src, menu, slot, num, wd};
        mreq_valid = 1'b1;
        @(negedge ref_clk);
        // the answer stands for this one cycle only: take it now
        {vl, e, rd} = {mrsp_valid, mrsp_err, mrsp_rdata};
        mreq_valid = 1'b0;
        req_q = ~req_q; // released lines never echo the old request
    endtask : access
endmodule : mpm_host_model

/* testbench/menu_parameter_mapper_bench.sv */
// menu_parameter_mapper_bench: self-checking bench for mpm_menu_mapper
// assumes: mpm_host_model plays the menu master, props bound to the design
`timescale 1ns/1ps
module menu_parameter_mapper_bench import mpm_pkg::*;;
    logic        ref_clk = 1'b0;
    logic        arst_n, cfg_wide, cfg_swap, cfg_par_ro, cfg_num_en, par_changed, svc_slot;
    logic [6:0]  cfg_menu, cfg_slot, mreq_menu, mreq_slot, ro;
    logic [15:0] cfg_drive_num, mreq_num;
    logic [31:0] par_value, mreq_wdata, mrsp_rdata, par_wdata, v, rd;
    logic [1:0]  mreq_src;
    logic        mreq_valid, mreq_write, mrsp_valid, mrsp_err, par_wr, e, vl;
    int          n_fail = 0;
    int          comparisons = 0;
    integer      seed = 64;
    always #2.5 ref_clk = ~ref_clk;
    mpm_menu_mapper #(.DW(32)) mpm_menu_mapper_inst (.ref_clk, .arst_n, .cfg_menu, .cfg_slot,
        .cfg_wide, .cfg_swap, .cfg_par_ro, .cfg_drive_num, .cfg_num_en, .par_value, .par_changed,
        .svc_slot, .mreq_valid, .mreq_write, .mreq_src, .mreq_menu, .mreq_slot, .mreq_num,
        .mreq_wdata, .mrsp_valid, .mrsp_err, .mrsp_rdata, .par_wr, .par_wdata);
    mpm_host_model mpm_host_model_inst (.ref_clk, .mreq_valid, .mreq_write, .mreq_src,
        .mreq_menu, .mreq_slot, .mreq_num, .mreq_wdata, .mrsp_valid, .mrsp_err, .mrsp_rdata);
    ////////////////////////////////////////////////////////////////////////
    // expected half of a split value in the lower or upper slot
    function automatic logic [31:0] half(input logic [31:0] x, input logic sw, input logic up);
        half = {16'h0000, (sw ^ up) ? x[31:16] : x[15:0]};
    endfunction : half
    task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            n_fail++;
            $display("[ERR] %s expected %h seen %h", name, exp, seen);
        end
    endtask : chk
    task automatic acc(input logic w, input logic [1:0] src, input logic [6:0] menu,
                       input logic [6:0] slot, input logic [31:0] wd);
        mpm_host_model_inst.access(w, src, menu, slot, cfg_drive_num, wd, vl, e, rd);
        chk("mrsp_valid", {31'h0000_0000, vl}, 32'h0000_0001);
    endtask : acc
    // mark the internal value changed, then give one service slot
    task automatic push(input logic [31:0] val);
        @(negedge ref_clk);
        par_value = val;
        par_changed = 1'b1;
        @(negedge ref_clk);
        par_changed = 1'b0;
        svc_slot = 1'b1;
        @(negedge ref_clk);
        svc_slot = 1'b0;
    endtask : push
    // service slot that should, or should not, write the internal side
    task automatic pull(input logic wr, input logic [31:0] exp);
        @(negedge ref_clk);
        svc_slot = 1'b1;
        @(negedge ref_clk);
        svc_slot = 1'b0;
        // write-back pulse stands for the one cycle after the copy state
        @(negedge ref_clk);
        chk("par_wr", {31'h0000_0000, par_wr}, {31'h0000_0000, wr});
        if (wr) chk("par_wdata", par_wdata, exp);
    endtask : pull
    task automatic tally_and_finish();
        $display("comparisons %0d n_fail %0d", comparisons, n_fail);
        if (n_fail == 0 && comparisons > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : tally_and_finish
    ////////////////////////////////////////////////////////////////////////
    initial begin
        #100000;
        n_fail++;
        tally_and_finish();
    end
    initial begin
        {arst_n, cfg_swap, cfg_par_ro, par_changed, svc_slot, par_value} = '0;
        {cfg_wide, cfg_num_en, cfg_menu, cfg_slot} = {2'h3, MPM_MENU_A, 7'h0b};
        cfg_drive_num = 16'h0123;
        repeat (3) @(negedge ref_clk);
        arst_n = 1'b1;
        // paired menus, both word orders
        for (int m = 0; m < 4; m++) begin
            {cfg_menu, cfg_swap} = {(m < 2) ? MPM_MENU_A : MPM_MENU_B, m[0]};
            v = $random(seed);
            push(v);
            acc(1'b0, MPM_SRC_CYCLIC, cfg_menu, 7'h0b, '0);
            chk("lower slot", rd & 32'h0000_ffff, half(v, cfg_swap, 1'b0));
            acc(1'b0, MPM_SRC_CYCLIC, cfg_menu, 7'h0c, '0);
            chk("upper slot", rd & 32'h0000_ffff, half(v, cfg_swap, 1'b1));
            v = $random(seed);
            acc(1'b1, MPM_SRC_CYCLIC, cfg_menu, 7'h0b, half(v, cfg_swap, 1'b0));
            acc(1'b1, MPM_SRC_CYCLIC, cfg_menu, 7'h0c, half(v, cfg_swap, 1'b1));
            pull(1'b1, v);
            ro = MPM_RO_FIRST + 7'({$random(seed)} % 9);
            acc(1'b1, MPM_SRC_CYCLIC, cfg_menu, ro, v);
            chk("ro slot write", {31'h0000_0000, e}, 32'h0000_0001);
            acc(1'b0, MPM_SRC_CYCLIC, cfg_menu, ro, '0);
            chk("ro slot read", rd, 32'h0000_0000);
        end
        // wide menu, numbered access and front panel refusal
        {cfg_menu, cfg_slot} = {MPM_MENU_W, 7'h1e};
        repeat (6) begin
            v = $random(seed);
            push(v);
            acc(1'b0, MPM_SRC_CYCLIC, MPM_MENU_W, 7'h1e, '0);
            chk("wide slot", rd, v);
            acc(1'b0, MPM_SRC_NONCYC, MPM_MENU_NUM, 7'h00, '0);
            chk("numbered read", rd, v);
            acc(1'b0, MPM_SRC_FRONT, MPM_MENU_NUM, 7'h00, '0);
            chk("front panel", {31'h0000_0000, e}, 32'h0000_0001);
        end
        acc(1'b0, MPM_SRC_CYCLIC, MPM_MENU_W, 7'h1f, '0);
        chk("next slot", {31'h0000_0000, e}, 32'h0000_0001);
        v = $random(seed);
        acc(1'b1, MPM_SRC_NONCYC, MPM_MENU_NUM, 7'h00, v);
        pull(1'b1, v);
        // read-only internal parameter
        cfg_par_ro = 1'b1;
        v = $random(seed);
        push(v);
        acc(1'b0, MPM_SRC_CYCLIC, MPM_MENU_W, 7'h1e, '0);
        chk("ro param read", rd, v);
        acc(1'b1, MPM_SRC_CYCLIC, MPM_MENU_W, 7'h1e, ~v);
        chk("ro param write", {31'h0000_0000, e}, 32'h0000_0001);
        pull(1'b0, v);
        tally_and_finish();
    end
endmodule : menu_parameter_mapper_bench
